// >>> core/timer_defs.vh
// Constants for the period match timer: register map, fields, resets.
// Assumes inclusion by bare name from files under core/.
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// Register byte offsets on the AHB-Lite slave
`define OFS_TIMER_COUNT   8'h00
`define OFS_TIMER_CONTROL 8'h04
`define OFS_PERIOD_VALUE  8'h08
`define OFS_INT_STATUS    8'h0c
`define OFS_INT_MASK      8'h10
`define ADDR_DEC_W        8

// Reset values
`define RST_TIMER_COUNT   8'h00
`define RST_TIMER_CONTROL 7'h00
`define RST_PERIOD_VALUE  8'hff

// Control field positions
`define CTL_PRE_LO        0
`define CTL_PRE_HI        1
`define CTL_RUN_BIT       2
`define CTL_POST_LO       3
`define CTL_POST_HI       6

// Prescaler terminal counts: divide by 1, 4, 16
`define PRE_LAST_DIV1     4'h0
`define PRE_LAST_DIV4     4'h3
`define PRE_LAST_DIV16    4'hf

// Instruction clock is the bus clock divided by four
`define INSTR_DIV_LAST    2'h3

// Interrupt status bit of the match flag
`define INT_MATCH_BIT     0

`endif

// >>> core/tick_prescaler.v
// Four-bit prescale counter between the instruction clock and the timer.
// Assumes step is a one-cycle enable on hclk; clear wins over step.
`timescale 1ns/100ps

module tick_prescaler (
    input wire hclk,
    input wire hresetn,
    input wire clear,
    input wire step,
    input wire [1:0] select,
    output wire tick
);
`include "timer_defs.vh"

    reg [3:0] count;
    reg [3:0] last;

    // Terminal count from the selection code; 1x both mean sixteen
    always @* begin
        case (select)
            2'b00: last = `PRE_LAST_DIV1;
            2'b01: last = `PRE_LAST_DIV4;
            default: last = `PRE_LAST_DIV16;
        endcase
    end

    assign tick = step && (count == last);

    // Count steps, wrap on the terminal count
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 4'h0;
        end else if (clear) begin
            count <= 4'h0;
        end else if (step) begin
            count <= (count == last) ? 4'h0 : count + 4'h1;
        end
    end

endmodule // tick_prescaler

// >>> core/period_match_timer8.v
// Eight-bit period match timer with prescaler, postscaler and interrupt,
// reached over an AHB-Lite slave port.
// Assumes a single AHB-Lite master, word accesses, hclk at 100 MHz.
//
// Function
// - Running count rises by one per prescaled tick
// - Four-bit prescale counter ahead of the timer
// - Prescale code 00 /1, 01 /4, 1x /16
// - Count equal to period raises match output
// - Match zeroes count and steps postscaler
// - Postscale code n gives n+1 matches per flag
// - Postscaler completion sets sticky match flag
// - Flag reaches interrupt only when enabled
// - Control bit 2 runs or stops timer
// - Count and period readable, writable, unbuffered
// - Reset clears count, period to all ones
// - Count write, control write, reset clear scalers
// - Control write leaves count unchanged
// - Control bit 7 ignores writes, reads zero
// - Unscaled match pulse drives PWM time base
// - Match offered as serial shift clock
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps

module period_match_timer8 (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg irq,
    output reg pwm_time_base,
    output reg spi_shift_clk
);
`include "timer_defs.vh"

    // Software visible state
    reg [7:0] timer_count;
    reg [6:0] timer_control;
    reg [7:0] period_value;
    reg match_int_flag;
    reg match_int_enable;

    // Internal counting state
    reg [1:0] instr_div;
    reg [3:0] post_count;

    // Registered address phase
    reg wr_pend;
    reg [7:0] wr_addr;

    wire [1:0] prescale_select;
    wire timer_run;
    wire [3:0] postscale_select;
    wire instr_tick;
    wire pre_tick;
    wire is_match;
    wire match_event;
    wire post_done;
    wire addr_take;
    wire rd_take;
    wire wr_count;
    wire wr_control;
    wire wr_period;
    wire wr_status;
    wire wr_mask;
    wire scaler_clear;
    wire status_read;
    reg [31:0] next_hrdata;

    // Control fields
    assign prescale_select = timer_control[`CTL_PRE_HI:`CTL_PRE_LO];
    assign timer_run = timer_control[`CTL_RUN_BIT];
    assign postscale_select = timer_control[`CTL_POST_HI:`CTL_POST_LO];

    // Bus decode: only NONSEQ/SEQ with hready high is a real transfer
    assign addr_take = hsel && hready && htrans[1];
    assign rd_take = addr_take && !hwrite;

    // Data phase write strobes and the address phase status read; sub-word sizes are treated as words
    assign wr_count = wr_pend && (wr_addr == `OFS_TIMER_COUNT);
    assign wr_control = wr_pend && (wr_addr == `OFS_TIMER_CONTROL);
    assign wr_period = wr_pend && (wr_addr == `OFS_PERIOD_VALUE);
    assign wr_status = wr_pend && (wr_addr == `OFS_INT_STATUS);
    assign wr_mask = wr_pend && (wr_addr == `OFS_INT_MASK);
    assign status_read = rd_take &&
        (haddr[`ADDR_DEC_W-1:0] == `OFS_INT_STATUS);

    // Either write resets both scalers, but only a count write loads
    assign scaler_clear = wr_count || wr_control;

    // Instruction clock enable: one hclk pulse in four
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_div <= 2'h0;
        end else begin
            instr_div <= (instr_div == `INSTR_DIV_LAST) ?
                2'h0 : instr_div + 2'h1;
        end
    end
    assign instr_tick = (instr_div == `INSTR_DIV_LAST);

    // Stepping is gated by the run bit so a stopped timer holds all
    // counters; the instruction divider runs free, which costs a phase
    // uncertainty of up to three hclk after restart
    tick_prescaler u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(scaler_clear),
        .step(instr_tick && timer_run),
        .select(prescale_select),
        .tick(pre_tick)
    );

    // Comparator looks every cycle; the event is the prescaled tick
    // that finds the count at the period value
    assign is_match = (timer_count == period_value);
    assign match_event = pre_tick && is_match && !wr_count;
    assign post_done = match_event &&
        (post_count == postscale_select);

    // Timer count register; a software write takes precedence
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_count <= `RST_TIMER_COUNT;
        end else if (wr_count) begin
            timer_count <= hwdata[7:0];
        end else if (match_event) begin
            timer_count <= 8'h00;
        end else if (pre_tick) begin
            timer_count <= timer_count + 8'h01;
        end
    end

    // Period register, loaded directly with no shadow copy
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_value <= `RST_PERIOD_VALUE;
        end else if (wr_period) begin
            period_value <= hwdata[7:0];
        end
    end

    // Control register; bit 7 is not stored at all
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control <= `RST_TIMER_CONTROL;
        end else if (wr_control) begin
            timer_control <= hwdata[6:0];
        end
    end

    // Postscaler counts matches and wraps when the flag fires
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            post_count <= 4'h0;
        end else if (scaler_clear) begin
            post_count <= 4'h0;
        end else if (post_done) begin
            post_count <= 4'h0;
        end else if (match_event) begin
            post_count <= post_count + 4'h1;
        end
    end

    // Sticky flag: a set in the same cycle as a clearing read wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_int_flag <= 1'b0;
        end else if (post_done) begin
            match_int_flag <= 1'b1;
        end else if (status_read) begin
            match_int_flag <= 1'b0;
        end
    end

    // Interrupt mask; writes to the status word are ignored since
    // reading it is the only way to clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_int_enable <= 1'b0;
        end else if (wr_mask) begin
            match_int_enable <= hwdata[`INT_MATCH_BIT];
        end
    end

    // Level interrupt, registered so it follows the flag by one cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= match_int_flag && match_int_enable;
        end
    end

    // Unscaled match pulse for the PWM units and the serial port;
    // one hclk wide, one cycle after the match event
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_time_base <= 1'b0;
            spi_shift_clk <= 1'b0;
        end else begin
            pwm_time_base <= match_event;
            spi_shift_clk <= match_event;
        end
    end

    // Read mux evaluated in the address phase, so data is ready in
    // the data phase with no wait state; unmapped reads return zero
    always @* begin
        next_hrdata = 32'h0000_0000;
        case (haddr[`ADDR_DEC_W-1:0])
            `OFS_TIMER_COUNT: next_hrdata[7:0] = timer_count;
            `OFS_TIMER_CONTROL: next_hrdata[7:0] =
                {1'b0, timer_control};
            `OFS_PERIOD_VALUE: next_hrdata[7:0] = period_value;
            `OFS_INT_STATUS: next_hrdata[`INT_MATCH_BIT] = match_int_flag;
            `OFS_INT_MASK: next_hrdata[`INT_MATCH_BIT] = match_int_enable;
            default: next_hrdata = 32'h0000_0000;
        endcase
    end

    // Address phase capture and read data register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_take && hwrite;
            if (addr_take) begin
                wr_addr <= haddr[`ADDR_DEC_W-1:0];
            end
            if (rd_take) begin
                hrdata <= next_hrdata;
            end
        end
    end

    // Zero wait state slave, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule // period_match_timer8

// >>> test/timer_port_monitor.sv
// Port checker for the period match timer.
// Assumes a bind onto period_match_timer8; one clock, hclk.
`timescale 1ns/100ps

module timer_port_monitor (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hrdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire irq,
    input wire pwm_time_base,
    input wire spi_shift_clk
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Address phase of a read or a write
    wire rd = hsel && hready && htrans[1] && !hwrite;
    wire wr = hsel && hready && htrans[1] && hwrite;
    reg [2:0] clr_win;

    // Window after a status read or mask write in which irq may drop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            clr_win <= 3'h0;
        else if ((rd && haddr[7:0] == 8'h0c) || (wr && haddr[7:0] == 8'h10))
            clr_win <= 3'h4;
        else if (clr_win != 3'h0)
            clr_win <= clr_win - 3'h1;
    end

    a_ready_high: assert property (hreadyout)
        else $error("hreadyout dropped");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    a_shift_same: assert property (spi_shift_clk == pwm_time_base)
        else $error("shift clock differs from time base");
    a_pulse_single: assert property (
        pwm_time_base |=> !pwm_time_base [*3])
        else $error("match pulse too long or too close");
    a_ctl_bit_seven: assert property (
        rd && haddr[7:0] == 8'h04 |=> hrdata[31:7] == 25'h0)
        else $error("control reads back bit seven");
    a_unmapped_zero: assert property (
        rd && haddr[7:0] == 8'h14 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_status_upper: assert property (
        rd && haddr[7:0] == 8'h0c |=> hrdata[31:1] == 31'h0)
        else $error("status upper bits set");
    a_irq_held: assert property ($fell(irq) |-> clr_win != 3'h0)
        else $error("irq dropped without clear");

    // Main scenarios reached
    c_pulse: cover property (pwm_time_base);
    c_irq: cover property ($rose(irq));
    c_clear: cover property (rd && haddr[7:0] == 8'h0c && irq);
endmodule // timer_port_monitor

// >>> test/period_match_timer8_tb.sv
// Self-checking bench for the period match timer.
// Assumes the bench is the only AHB-Lite master.
`timescale 1ns/100ps

module period_match_timer8_tb;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b1;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, pwm_time_base, spi_shift_clk;
    int fail_count = 0;
    int tests_run = 0;
    int n, g, k;
    logic [31:0] rd, v;

    // 100 MHz clock
    always #5 hclk = ~hclk;

    period_match_timer8 period_match_timer8_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .pwm_time_base(pwm_time_base),
        .spi_shift_clk(spi_shift_clk));

    task summarize;
        if (fail_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask

    // One edge; a spent bound ends the run so no wait hangs
    task step(input int lim);
        @(posedge hclk);
        n++;
        if (n > lim) begin
            fail_count++;
            $display("BAD %0t timeout", $time);
            summarize;
        end
    endtask

    // Single word transfer; read data taken at the data phase edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        n = 0;
        do step(50); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        n = 0;
        do step(50); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Edges up to and including the next match pulse
    task gap;
        n = 0;
        do step(1000); while (pwm_time_base !== 1'b1);
        g = n;
    endtask

    task reset_values;
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            check(rd, (i == 2) ? 32'hff : 32'h0);
        end
    endtask

    task reg_access;
        bus(1'b1, 8'h00, 32'ha5);
        bus(1'b1, 8'h08, 32'h3c);
        bus(1'b1, 8'h04, 32'hfb);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'ha5);
        bus(1'b0, 8'h04, 32'h0);
        check(rd, 32'h7b);
        bus(1'b0, 8'h08, 32'h0);
        check(rd, 32'h3c);
        bus(1'b1, 8'h14, 32'hffffffff);
        bus(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0);
    endtask

    // Period 2: three ticks per match; 4, 16, 64 clocks per tick for codes 0, 1, 1x
    task prescale_gaps;
        bus(1'b1, 8'h08, 32'h2);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 8'h04, 32'(c + 4));
            gap;
            gap;
            check(g, c == 0 ? 12 : c == 1 ? 48 : 192);
        end
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
    endtask

    // Postscale code 2: flag on every third match
    task postscale;
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b0, 8'h0c, 32'h0);
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h04, 32'h14);
        k = 0;
        n = 0;
        do begin
            step(200);
            if (pwm_time_base === 1'b1)
                k++;
        end while (irq !== 1'b1);
        check(k, 3);
        bus(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h1);
        bus(1'b1, 8'h10, 32'h0);
        repeat (40) @(posedge hclk);
        check(irq, 1'b0);
        bus(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h1);
    endtask

    // Stopped timer: count holds, no pulses
    task stop_hold;
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b0, 8'h00, 32'h0);
        v = rd;
        k = 0;
        repeat (30) begin
            @(posedge hclk);
            if (pwm_time_base === 1'b1)
                k++;
        end
        check(k, 0);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, v);
    endtask

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_values;
        reg_access;
        prescale_gaps;
        postscale;
        stop_hold;
        summarize;
    end
endmodule // period_match_timer8_tb

bind period_match_timer8 timer_port_monitor timer_port_monitor_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .pwm_time_base(pwm_time_base), .spi_shift_clk(spi_shift_clk));
